// >>> rtl/aao_core.sv
// accumulator alu core with its ahb-lite register slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module aao_core (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// chip side
	input wire logic wake_req,
	output logic [7:0] port_out,
	output logic osc_stop
);

	logic dp_valid;
	logic dp_write;
	logic dp_word;
	logic [7:0] dp_addr;
	logic rd_ready;
	logic stall;
	logic bus_wr;
	logic ctrl_fire;
	logic [31:0] instr;
	logic busy;
	logic [1:0] cnt;
	logic commit;
	logic [7:0] work;
	logic [5:0] flags;
	logic [10:0] pc;
	logic [2:0] sp;
	logic [10:0] stack [aao_pkg::STACK_DEPTH];
	logic [7:0] mem [aao_pkg::MEM_WORDS];
	logic asleep;
	logic [7:0] port;
	logic in_mem;
	logic [3:0] mem_idx;
	aao_pkg::aao_op_t i_op;
	logic i_dest;
	logic [2:0] i_bit;
	logic [3:0] i_maddr;
	logic [15:0] i_imm;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_ov;
	logic upd_arith;
	logic upd_c;
	logic upd_z;

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic two_cycle(input aao_pkg::aao_op_t op);
		two_cycle = (op == aao_pkg::op_goto_far) || (op == aao_pkg::op_sub_exit) ||
			(op == aao_pkg::op_sub_exit_with_literal) ||
			(op == aao_pkg::op_irq_exit) || (op == aao_pkg::op_sub_invoke);
	endfunction

	function automatic logic to_mem(input aao_pkg::aao_op_t op, input logic dest);
		unique case (op)
			aao_pkg::op_store_mem, aao_pkg::op_fill_ones,
			aao_pkg::op_force_one_bit: to_mem = 1'h1;
			aao_pkg::op_work_minus_mem_borrow, aao_pkg::op_bump, aao_pkg::op_or,
			aao_pkg::op_rot_left_thru_carry, aao_pkg::op_rot_left_plain,
			aao_pkg::op_rot_right_thru_carry, aao_pkg::op_rot_right_plain,
			aao_pkg::op_mem_minus_work, aao_pkg::op_mem_minus_work_borrow,
			aao_pkg::op_nibble_exchange: to_mem = dest;
			default: to_mem = 1'h0;
		endcase
	endfunction

	function automatic logic to_work(input aao_pkg::aao_op_t op, input logic dest);
		unique case (op)
			aao_pkg::op_load_work, aao_pkg::op_literal_to_work, aao_pkg::op_or_literal,
			aao_pkg::op_sub_exit_with_literal,
			aao_pkg::op_literal_minus_work: to_work = 1'h1;
			aao_pkg::op_work_minus_mem_borrow, aao_pkg::op_bump, aao_pkg::op_or,
			aao_pkg::op_rot_left_thru_carry, aao_pkg::op_rot_left_plain,
			aao_pkg::op_rot_right_thru_carry, aao_pkg::op_rot_right_plain,
			aao_pkg::op_mem_minus_work, aao_pkg::op_mem_minus_work_borrow,
			aao_pkg::op_nibble_exchange: to_work = !dest;
			default: to_work = 1'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// instruction fields and alu
	assign i_op = aao_pkg::aao_op_t'(instr[aao_pkg::CTRL_OP_LSB +: aao_pkg::OPW]);
	assign i_dest = instr[aao_pkg::CTRL_DEST];
	assign i_bit = instr[aao_pkg::CTRL_BIT_LSB +: 3];
	assign i_maddr = instr[aao_pkg::CTRL_MADDR_LSB +: aao_pkg::MAW];
	assign i_imm = instr[aao_pkg::CTRL_IMM_LSB +: 16];
	assign commit = busy && (cnt == aao_pkg::CYC_ONE);

	aao_alu u_alu (
		.op(i_op),
		.bit_sel(i_bit),
		.c_in(flags[aao_pkg::FL_C]),
		.work(work),
		.mem(mem[i_maddr]),
		.imm(i_imm[7:0]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.ov_out(alu_ov),
		.upd_arith(upd_arith),
		.upd_c(upd_c),
		.upd_z(upd_z)
	);

	////////////////////////////////////////////////////////////////////////
	// bus handshake: reads take one wait state, all access waits while busy
	assign stall = dp_valid && (busy || (!dp_write && !rd_ready));
	assign hreadyout = !stall;
	assign hresp = 1'h0;
	assign bus_wr = dp_valid && dp_write && dp_word && !stall;
	assign ctrl_fire = bus_wr && (dp_addr == aao_pkg::OFF_CTRL) && !asleep;
	assign in_mem = (dp_addr >= aao_pkg::OFF_MEM_FIRST) && (dp_addr <= aao_pkg::OFF_MEM_LAST);
	assign mem_idx = 4'((dp_addr - aao_pkg::OFF_MEM_FIRST) >> aao_pkg::WORD_SHIFT);
	assign port_out = port;
	assign osc_stop = asleep;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'h0;
			dp_write <= 1'h0;
			dp_word <= 1'h0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_valid <= hsel && ((htrans == aao_pkg::HTRANS_NONSEQ) ||
				(htrans == aao_pkg::HTRANS_SEQ));
			dp_write <= hwrite;
			dp_word <= (hsize == aao_pkg::HSIZE_WORD);
			dp_addr <= haddr[7:0];
		end
	end

	// read data, taken in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ready <= 1'h0;
			hrdata <= 32'h00000000;
		end else begin
			rd_ready <= dp_valid && !dp_write && !busy && !rd_ready;
			if (dp_valid && !dp_write && !busy && !rd_ready) begin
				hrdata <= 32'h00000000;
				if (in_mem) begin
					hrdata[7:0] <= mem[mem_idx];
				end else begin
					unique case (dp_addr)
						aao_pkg::OFF_CTRL: hrdata <= instr;
						aao_pkg::OFF_WORK: hrdata[7:0] <= work;
						aao_pkg::OFF_FLAGS: begin
							hrdata[aao_pkg::FL_PD:aao_pkg::FL_C] <= flags;
							hrdata[aao_pkg::FL_BUSY] <= busy;
							hrdata[aao_pkg::FL_ASLEEP] <= asleep;
						end
						aao_pkg::OFF_PC: begin
							hrdata[aao_pkg::PCW-1:0] <= pc;
							hrdata[aao_pkg::PCR_SP_LSB +: aao_pkg::SPW] <= sp;
						end
						aao_pkg::OFF_PORT: hrdata[7:0] <= port;
						default: hrdata <= 32'h00000000;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// instruction issue and cycle count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr <= 32'h00000000;
			busy <= 1'h0;
			cnt <= 2'h0;
		end else if (ctrl_fire) begin
			instr <= hwdata;
			busy <= 1'h1;
			cnt <= two_cycle(aao_pkg::aao_op_t'(hwdata[aao_pkg::CTRL_OP_LSB +: aao_pkg::OPW])) ?
				aao_pkg::CYC_TWO : aao_pkg::CYC_ONE;
		end else if (busy) begin
			cnt <= cnt - aao_pkg::CYC_ONE;
			busy <= !commit;
		end
	end

	// working register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			work <= aao_pkg::WORK_RST;
		end else if (commit && to_work(i_op, i_dest)) begin
			work <= alu_res;
		end else if (bus_wr && (dp_addr == aao_pkg::OFF_WORK)) begin
			work <= hwdata[7:0];
		end
	end

	// status flags; only the flags an operation names are touched
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= aao_pkg::FLAGS_RST;
		end else if (commit) begin
			if (upd_arith) begin
				flags[aao_pkg::FL_C] <= alu_c;
				flags[aao_pkg::FL_DC] <= alu_dc;
				flags[aao_pkg::FL_OV] <= alu_ov;
			end
			if (upd_c) begin
				flags[aao_pkg::FL_C] <= alu_c;
			end
			if (upd_z) begin
				flags[aao_pkg::FL_Z] <= (alu_res == 8'h00);
			end
			if (i_op == aao_pkg::op_sleep) begin
				flags[aao_pkg::FL_TO] <= 1'h1;
				flags[aao_pkg::FL_PD] <= 1'h0;
			end
		end else if (bus_wr && (dp_addr == aao_pkg::OFF_FLAGS)) begin
			flags[aao_pkg::FL_OV:aao_pkg::FL_C] <= hwdata[aao_pkg::FL_OV:aao_pkg::FL_C];
		end
	end

	// program counter and stack pointer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= aao_pkg::PC_RST;
			sp <= 3'h0;
		end else if (commit) begin
			unique case (i_op)
				aao_pkg::op_goto_far: pc <= i_imm[aao_pkg::PCW-1:0];
				aao_pkg::op_sub_invoke: begin
					pc <= i_imm[aao_pkg::PCW-1:0];
					sp <= sp + 3'h1;
				end
				aao_pkg::op_sub_exit, aao_pkg::op_sub_exit_with_literal,
				aao_pkg::op_irq_exit: begin
					pc <= stack[sp - 3'h1];
					sp <= sp - 3'h1;
				end
				default: pc <= pc + 11'h001;
			endcase
		end else if (bus_wr && (dp_addr == aao_pkg::OFF_PC)) begin
			pc <= hwdata[aao_pkg::PCW-1:0];
		end
	end

	// return stack, circular
	always_ff @(posedge hclk) begin
		if (commit && (i_op == aao_pkg::op_sub_invoke)) begin
			stack[sp] <= pc + 11'h001;
		end
	end

	// data memory
	always_ff @(posedge hclk) begin
		if (commit && to_mem(i_op, i_dest)) begin
			mem[i_maddr] <= alu_res;
		end else if (bus_wr && in_mem) begin
			mem[mem_idx] <= hwdata[7:0];
		end
	end

	// sleep state and port latch; the latch is frozen while asleep
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			asleep <= 1'h0;
			port <= aao_pkg::PORT_RST;
		end else begin
			if (commit && (i_op == aao_pkg::op_sleep)) begin
				asleep <= 1'h1;
			end else if (wake_req) begin
				asleep <= 1'h0;
			end
			if (bus_wr && (dp_addr == aao_pkg::OFF_PORT) && !asleep) begin
				port <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_bump_z_only: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && (i_op == aao_pkg::op_bump) |=> $stable(flags[aao_pkg::FL_C]) &&
		$stable(flags[aao_pkg::FL_DC]) && $stable(flags[aao_pkg::FL_OV]))
		else $error("increment changed a flag other than zero");

	a_goto_target: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_fire && (hwdata[aao_pkg::OPW-1:0] == aao_pkg::op_goto_far) |=>
		busy [*2] ##1 (!busy && (pc == $past(instr[aao_pkg::CTRL_IMM_LSB +: aao_pkg::PCW]))))
		else $error("jump did not land in two cycles");

	a_single_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_fire && !two_cycle(aao_pkg::aao_op_t'(hwdata[aao_pkg::OPW-1:0])) |=>
		busy ##1 !busy)
		else $error("one cycle instruction took longer");

	a_store_flags: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && (i_op == aao_pkg::op_store_mem) |=> $stable(flags) &&
		(mem[$past(i_maddr)] == $past(work)))
		else $error("store went wrong");

	a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && upd_z |=> flags[aao_pkg::FL_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag does not match result");

	a_return_point: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && (i_op == aao_pkg::op_sub_invoke) |=>
		(stack[$past(sp)] == $past(pc) + 11'h001) && (sp == $past(sp) + 3'h1))
		else $error("call did not save its return point");

	a_sub_result: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && (i_op == aao_pkg::op_mem_minus_work) && !i_dest |=>
		work == 8'($past(mem[i_maddr]) - $past(work)))
		else $error("subtraction result wrong");

	a_sleep_port: assert property (@(posedge hclk) disable iff (!hresetn)
		asleep && $past(asleep) |-> $stable(port_out))
		else $error("port changed while asleep");

	a_sleep_flags: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && (i_op == aao_pkg::op_sleep) |=> osc_stop && flags[aao_pkg::FL_TO] &&
		!flags[aao_pkg::FL_PD])
		else $error("sleep entry incomplete");

endmodule // aao_core

// >>> rtl/aao_pkg.sv
// constants, register map and operation codes of the accumulator alu block
package aao_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths and sizes
	localparam int unsigned DW = 8;
	localparam int unsigned PCW = 11;
	localparam int unsigned MEM_WORDS = 16;
	localparam int unsigned MAW = 4;
	localparam int unsigned STACK_DEPTH = 8;
	localparam int unsigned SPW = 3;
	localparam int unsigned OPW = 5;
	localparam int unsigned WORD_SHIFT = 2;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_WORK = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_PC = 8'h0C;
	localparam logic [7:0] OFF_PORT = 8'h10;
	localparam logic [7:0] OFF_MEM_FIRST = 8'h40;
	localparam logic [7:0] OFF_MEM_LAST = 8'h7C;

	////////////////////////////////////////////////////////////////////////
	// field positions of the instruction word
	localparam int unsigned CTRL_OP_LSB = 0;
	localparam int unsigned CTRL_DEST = 5;
	localparam int unsigned CTRL_BIT_LSB = 6;
	localparam int unsigned CTRL_MADDR_LSB = 12;
	localparam int unsigned CTRL_IMM_LSB = 16;

	// flag register and pc register bit positions
	localparam int unsigned FL_C = 0;
	localparam int unsigned FL_DC = 1;
	localparam int unsigned FL_Z = 2;
	localparam int unsigned FL_OV = 3;
	localparam int unsigned FL_TO = 4;
	localparam int unsigned FL_PD = 5;
	localparam int unsigned FL_BUSY = 8;
	localparam int unsigned FL_ASLEEP = 9;
	localparam int unsigned PCR_SP_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// reset values, counts and bus codes
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h30;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	// operations in the order of their codes
	typedef enum logic [4:0] {
		op_nop, op_work_minus_mem_borrow, op_bump, op_goto_far, op_load_work,
		op_store_mem, op_literal_to_work, op_or_literal, op_or, op_sub_exit,
		op_sub_exit_with_literal, op_irq_exit, op_rot_left_thru_carry,
		op_rot_left_plain, op_rot_right_thru_carry, op_rot_right_plain,
		op_fill_ones, op_force_one_bit, op_sleep, op_literal_minus_work,
		op_mem_minus_work, op_mem_minus_work_borrow, op_nibble_exchange,
		op_sub_invoke
	} aao_op_t;

endpackage

// >>> rtl/aao_alu.sv
// combinational result and flag logic of the accumulator alu
`timescale 1ns/1ps
module aao_alu (
	// operation
	input wire aao_pkg::aao_op_t op,
	input wire logic [2:0] bit_sel,
	input wire logic c_in,
	// operands
	input wire logic [7:0] work,
	input wire logic [7:0] mem,
	input wire logic [7:0] imm,
	// results
	output logic [7:0] res,
	output logic c_out,
	output logic dc_out,
	output logic ov_out,
	output logic upd_arith,
	output logic upd_c,
	output logic upd_z
);

	logic [10:0] s;
	logic use_sub;

	////////////////////////////////////////////////////////////////////////
	// a minus b minus borrow: {borrow, nibble borrow, overflow, difference}
	function automatic logic [10:0] sub3(input logic [7:0] a, input logic [7:0] b,
		input logic bin);
		logic [8:0] d;
		logic [4:0] n;
		d = {1'h0, a} - {1'h0, b} - {8'h00, bin};
		n = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, bin};
		sub3 = {d[8], n[4], (a[7] ^ b[7]) & (a[7] ^ d[7]), d[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// result and flag selection; results wrap at eight bits
	always_comb begin
		s = 11'h000;
		use_sub = 1'h0;
		res = mem;
		c_out = c_in;
		dc_out = 1'h0;
		ov_out = 1'h0;
		upd_arith = 1'h0;
		upd_c = 1'h0;
		upd_z = 1'h0;
		unique case (op)
			aao_pkg::op_work_minus_mem_borrow: begin
				s = sub3(work, mem, c_in);
				use_sub = 1'h1;
			end
			aao_pkg::op_bump: begin
				res = mem + 8'h01;
				upd_z = 1'h1;
			end
			aao_pkg::op_load_work: begin
				res = mem;
				upd_z = 1'h1;
			end
			aao_pkg::op_store_mem: res = work;
			aao_pkg::op_literal_to_work: res = imm;
			aao_pkg::op_sub_exit_with_literal: res = imm;
			aao_pkg::op_or_literal: begin
				res = work | imm;
				upd_z = 1'h1;
			end
			aao_pkg::op_or: begin
				res = work | mem;
				upd_z = 1'h1;
			end
			aao_pkg::op_rot_left_thru_carry: begin
				res = {mem[6:0], c_in};
				c_out = mem[7];
				upd_c = 1'h1;
			end
			aao_pkg::op_rot_left_plain: res = {mem[6:0], mem[7]};
			aao_pkg::op_rot_right_thru_carry: begin
				res = {c_in, mem[7:1]};
				c_out = mem[0];
				upd_c = 1'h1;
			end
			aao_pkg::op_rot_right_plain: res = {mem[0], mem[7:1]};
			aao_pkg::op_fill_ones: res = 8'hFF;
			aao_pkg::op_force_one_bit: res = mem | (8'h01 << bit_sel);
			aao_pkg::op_literal_minus_work: begin
				s = sub3(imm, work, 1'h0);
				use_sub = 1'h1;
			end
			aao_pkg::op_mem_minus_work: begin
				s = sub3(mem, work, 1'h0);
				use_sub = 1'h1;
			end
			aao_pkg::op_mem_minus_work_borrow: begin
				s = sub3(mem, work, c_in);
				use_sub = 1'h1;
			end
			aao_pkg::op_nibble_exchange: res = {mem[3:0], mem[7:4]};
			default: res = mem;
		endcase
		if (use_sub) begin
			res = s[7:0];
			c_out = s[10];
			dc_out = s[9];
			ov_out = s[8];
			upd_arith = 1'h1;
			upd_z = 1'h1;
		end
	end

endmodule // aao_alu

// >>> testbench/testbench.sv
// self-checking bench of the accumulator alu core over its ahb-lite register port
`timescale 1ns/1ps
module testbench;

	////////////////////////////////////////////////////////////////////////
	// signals and bench state
	logic hclk = 1'b0;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic wake_req;
	wire hready;
	wire hreadyout;
	wire hresp;
	wire [31:0] hrdata;
	wire [7:0] port_out;
	wire osc_stop;
	int err_count;
	int n_tests;
	int wt;
	logic [31:0] rdv;
	logic [10:0] pc_exp;
	logic [19:0] e;
	logic [4:0] op;
	logic [3:0] ma;
	logic [4:0] ops[17] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0D,
		5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13, 5'h14, 5'h15, 5'h16};
	logic [7:0] sw[4] = '{8'h77, 8'h77, 8'h01, 8'h80};
	logic [7:0] sm[4] = '{8'h80, 8'h80, 8'h01, 8'h7F};
	logic [7:0] si[4] = '{8'h80, 8'h80, 8'h01, 8'h35};
	logic [3:0] sf[4] = '{4'h0, 4'h1, 4'hE, 4'h5};

	// clock of 25 ns and the single slave's ready as bus ready
	always #12.5 hclk = ~hclk;
	assign hready = hreadyout;

	aao_core i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake_req(wake_req),
		.port_out(port_out), .osc_stop(osc_stop)
	);

	////////////////////////////////////////////////////////////////////////
	// bus cycles, comparison and verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= aao_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= aao_pkg::HSIZE_WORD;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		wt = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			wt++;
			@(posedge hclk);
		end
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rdv, exp);
	endtask

	// issue one instruction, then time the stall of a following port write;
	// the first execution cycle overlaps the next address phase, so the data
	// phase waits one cycle less than the instruction runs
	task automatic run_op(input logic [4:0] o, input logic d, input logic [2:0] b,
		input logic [3:0] m, input logic [15:0] imm);
		wr(aao_pkg::OFF_CTRL, {imm, m, 3'h0, b, d, o});
		wr(aao_pkg::OFF_PORT, 32'h000000A5);
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic logic [7:0] ma_addr(input logic [3:0] a);
		return aao_pkg::OFF_MEM_FIRST + {2'h0, a, 2'h0};
	endfunction

	// expected {work, memory, flags} of one instruction
	function automatic logic [19:0] model(input logic [4:0] o, input logic d, input logic [2:0] b,
		input logic [7:0] w, input logic [7:0] m, input logic [7:0] i, input logic [3:0] f);
		logic [7:0] r;
		logic [7:0] x;
		logic [7:0] y;
		logic [8:0] s;
		logic [3:0] g;
		logic cin;
		logic sb;
		logic mw;
		r = w;
		x = m;
		y = w;
		g = f;
		mw = d;
		cin = 1'b0;
		sb = 1'b0;
		case (o)
			5'h01: begin x = w; y = m; cin = f[0]; sb = 1'b1; end
			5'h13: begin x = i; sb = 1'b1; mw = 1'b0; end
			5'h14: sb = 1'b1;
			5'h15: begin cin = f[0]; sb = 1'b1; end
			5'h02: begin r = m + 8'h01; g[2] = (r == 8'h00); end
			5'h04: begin r = m; g[2] = (r == 8'h00); mw = 1'b0; end
			5'h05: mw = 1'b1;
			5'h06: begin r = i; mw = 1'b0; end
			5'h07: begin r = w | i; g[2] = (r == 8'h00); mw = 1'b0; end
			5'h08: begin r = w | m; g[2] = (r == 8'h00); end
			5'h0C: begin r = {m[6:0], f[0]}; g[0] = m[7]; end
			5'h0D: r = {m[6:0], m[7]};
			5'h0E: begin r = {f[0], m[7:1]}; g[0] = m[0]; end
			5'h0F: r = {m[0], m[7:1]};
			5'h10: begin r = 8'hFF; mw = 1'b1; end
			5'h11: begin r = m | (8'h01 << b); mw = 1'b1; end
			5'h16: r = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (sb) begin
			s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
			r = s[7:0];
			g[0] = s[8];
			g[1] = ({1'b0, x[3:0]} < ({1'b0, y[3:0]} + {4'h0, cin}));
			g[2] = (r == 8'h00);
			g[3] = (x[7] != y[7]) && (r[7] != x[7]);
		end
		return mw ? {w, r, g} : {r, m, g};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#(25 * 40000);
		err_count++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h00000000;
		wake_req = 1'b0;
		hresetn = 1'b0;
		err_count = 0;
		n_tests = 0;
		pc_exp = 11'h000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values and an unmapped place
		rchk(aao_pkg::OFF_WORK, 32'h00000000);
		rchk(aao_pkg::OFF_FLAGS, 32'h00000030);
		rchk(aao_pkg::OFF_PC, 32'h00000000);
		rchk(8'h20, 32'h00000000);
		chk({31'h00000000, hresp}, 32'h00000000);
		// every data operation, both destinations except for 04, 05, 10 and 11, four operand sets
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 17; j++) begin
				for (int d = 0; d < 2; d++) begin
					op = ops[j];
					if ((op == 5'h04 && d == 1) || ((op == 5'h05 || op == 5'h10 || op == 5'h11) && d == 0))
						continue;
					ma = 4'(k * 3 + 1);
					wr(aao_pkg::OFF_WORK, {24'h000000, sw[k]});
					wr(ma_addr(ma), {24'h000000, sm[k]});
					wr(aao_pkg::OFF_FLAGS, {28'h0000000, sf[k]});
					e = model(op, d[0], 3'(k * 2 + 1), sw[k], sm[k], si[k], sf[k]);
					run_op(op, d[0], 3'(k * 2 + 1), ma, {8'h00, si[k]});
					pc_exp = pc_exp + 11'h001;
					chk(32'(wt), 32'h00000000);
					rchk(aao_pkg::OFF_WORK, {24'h000000, e[19:12]});
					rchk(ma_addr(ma), {24'h000000, e[11:4]});
					rchk(aao_pkg::OFF_FLAGS, {24'h000000, 4'h3, e[3:0]});
					rchk(aao_pkg::OFF_PC, {21'h000000, pc_exp});
				end
			end
		end
		// jump, calls and the three returns keep flags
		wr(aao_pkg::OFF_FLAGS, 32'h00000005);
		run_op(5'h03, 1'b0, 3'h0, 4'h0, 16'h0123);
		chk(32'(wt), 32'h00000001);
		rchk(aao_pkg::OFF_PC, 32'h00000123);
		run_op(5'h17, 1'b0, 3'h0, 4'h0, 16'h0200);
		rchk(aao_pkg::OFF_PC, 32'h00010200);
		run_op(5'h09, 1'b0, 3'h0, 4'h0, 16'h0000);
		rchk(aao_pkg::OFF_PC, 32'h00000124);
		run_op(5'h17, 1'b0, 3'h0, 4'h0, 16'h0300);
		run_op(5'h0A, 1'b0, 3'h0, 4'h0, 16'h0035);
		rchk(aao_pkg::OFF_WORK, 32'h00000035);
		rchk(aao_pkg::OFF_PC, 32'h00000125);
		run_op(5'h17, 1'b0, 3'h0, 4'h0, 16'h0400);
		run_op(5'h0B, 1'b0, 3'h0, 4'h0, 16'h0000);
		chk(32'(wt), 32'h00000001);
		rchk(aao_pkg::OFF_PC, 32'h00000126);
		rchk(aao_pkg::OFF_FLAGS, 32'h00000035);
		// sleep: flags, stopped oscillator, frozen port, ignored instruction
		run_op(5'h12, 1'b0, 3'h0, 4'h0, 16'h0000);
		rchk(aao_pkg::OFF_FLAGS, 32'h00000215);
		chk({31'h00000000, osc_stop}, 32'h00000001);
		wr(aao_pkg::OFF_PORT, 32'h0000005A);
		@(posedge hclk);
		chk({24'h000000, port_out}, 32'h000000A5);
		run_op(5'h06, 1'b0, 3'h0, 4'h0, 16'h0077);
		rchk(aao_pkg::OFF_WORK, 32'h00000035);
		rchk(aao_pkg::OFF_PC, 32'h00000127);
		// wake up and drive the port again
		wake_req <= 1'b1;
		repeat (2) @(posedge hclk);
		wake_req <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({31'h00000000, osc_stop}, 32'h00000000);
		wr(aao_pkg::OFF_PORT, 32'h0000003C);
		@(posedge hclk);
		chk({24'h000000, port_out}, 32'h0000003C);
		report_and_stop();
	end

endmodule // testbench
